// ### rtl/swi_pkg.sv
// Package for the system-interface write engine: command encodings,
// field positions, register offsets, reset values and carrier structs.
// Assumes a 32-bit AHB-Lite register bus and a 5-bit command bus.
package swi_pkg;

	// Command bus field positions
	localparam int CMD_W       = 5;
	localparam int CMD_TOP_BIT = 4;     // 0 request, 1 data identifier
	localparam int CMD_TYP_BIT = 3;     // Request type / last element
	localparam int CMD_ATT_BIT = 2;     // Attribute / response data
	localparam int CMD_ERR_BIT = 1;     // Error indication
	localparam int CMD_CHK_BIT = 0;     // Data check disable

	// Command field values
	localparam logic [1:0] BLK_2W   = 2'h0;
	localparam logic [1:0] BLK_4W   = 2'h1;
	localparam logic [1:0] SZ_BYTE  = 2'h0;
	localparam logic [1:0] SZ_HALF  = 2'h1;
	localparam logic [1:0] SZ_TRI   = 2'h2;
	localparam logic [1:0] SZ_WORD  = 2'h3;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;  // Go, block, size, endian
	localparam logic [7:0] OFS_ADDR  = 8'h04;  // Write address
	localparam logic [7:0] OFS_STAT  = 8'h08;  // Busy, sticky events
	localparam logic [7:0] OFS_IEN   = 8'h0c;  // Interrupt enable
	localparam logic [7:0] OFS_ICLR  = 8'h10;  // Write-one-to-clear
	localparam logic [7:0] OFS_RXDAT = 8'h14;  // Last received word
	localparam logic [7:0] OFS_RXID  = 8'h18;  // Last received id
	localparam logic [7:0] OFS_DATA0 = 8'h20;  // Eight write data words

	// Control field positions
	localparam int CTL_GO   = 0;
	localparam int CTL_BLK  = 1;
	localparam int CTL_SZ   = 2;        // Two bits
	localparam int CTL_BIGE = 4;

	// Event bit positions
	localparam int EV_DONE = 0;         // Write finished
	localparam int EV_RX   = 1;         // Word received
	localparam int EV_BERR = 2;         // Bus error data received
	localparam int EV_NUM  = 3;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Command bus word as seen on the wire
	typedef struct packed {
		logic       top;
		logic       typ;
		logic       att;
		logic       err;
		logic       chk;
	} swi_cmd_s;

	// Link-side outputs of the device
	typedef struct packed {
		logic [31:0] ad;
		swi_cmd_s    cmd;
		logic        valid;
	} swi_link_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10
	} swi_state_e;

endpackage : swi_pkg

// ### rtl/swi_write_engine.sv
// Write request engine facing the shared address/data and command buses.
// Assumes one external agent on a shared synchronous bus clock, and an
// AHB-Lite master reaching the registers; link inputs are synchronised.
`timescale 1ns/1ps

module swi_write_engine
	import swi_pkg::*;
(
	input  wire logic        ref_clk,     // System clock 25 MHz
	input  wire logic        rst_n,       // Async reset, active low
	input  wire logic        hsel,        // AHB slave select
	input  wire logic [7:0]  haddr,       // AHB byte address
	input  wire logic [1:0]  htrans,      // AHB transfer type
	input  wire logic        hwrite,      // AHB write
	input  wire logic [2:0]  hsize,       // AHB size
	input  wire logic [31:0] hwdata,      // AHB write data
	input  wire logic        hready,      // AHB bus ready
	output logic      [31:0] hrdata,      // AHB read data
	output logic             hreadyout,   // AHB slave ready
	output logic             hresp,       // AHB response, always OKAY
	output logic      [31:0] adOut,       // Address/data bus out
	output logic             adOe,        // Address/data drive enable
	input  wire logic [31:0] adIn,        // Address/data bus in
	output logic      [4:0]  cmdOut,      // Command/id bus out
	output logic             cmdOe,       // Command bus drive enable
	input  wire logic [4:0]  cmdIn,       // Command/id bus in
	output logic             validOut,    // Device drives a valid cycle
	input  wire logic        validIn,     // Agent drives a valid cycle
	output logic             irq          // Level interrupt
);

	////////////////////////////////////////////////////////////////////
	// Input stages: four flops on the shared-clock link; each agent word
	// stands for one cycle only, so no agreement filter can be applied

	logic [37:0] syn1_ff, syn2_ff, syn3_ff;   // Sync stages
	logic [37:0] syncd_ff;                    // Accepted value
	logic [37:0] nxt_syncd;                   // Next accepted value
	logic [31:0] rxAd;                        // Synchronised data
	logic [4:0]  rxCmd;                       // Synchronised id
	logic        rxValid;                     // Synchronised valid

	// Take the third stage every cycle so single-cycle words survive
	always_comb
	begin
		nxt_syncd = syn3_ff;
	end

	// Register synchroniser stages
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syn1_ff  <= '0;
			syn2_ff  <= '0;
			syn3_ff  <= '0;
			syncd_ff <= '0;
		end
		else
		begin
			syn1_ff  <= {validIn, cmdIn, adIn};
			syn2_ff  <= syn1_ff;
			syn3_ff  <= syn2_ff;
			syncd_ff <= nxt_syncd;
		end
	end

	assign rxAd    = syncd_ff[31:0];
	assign rxCmd   = syncd_ff[36:32];
	assign rxValid = syncd_ff[37];

	// Every valid cycle with the top bit set: one word per cycle from the agent
	logic rxPrev_ff;                          // Previous valid
	logic rxWord;                             // Word taken this cycle
	assign rxWord = rxValid && rxCmd[CMD_TOP_BIT] &&
		(!rxPrev_ff || syncd_ff != nxt_syncd || 1'b1);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rxPrev_ff <= 1'b0;
		else
			rxPrev_ff <= rxValid;
	end

	////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, OKAY always

	logic        wrPend_ff, nxt_wrPend;       // Write data phase pending
	logic [7:0]  wrAddr_ff, nxt_wrAddr;       // Latched write address
	logic [31:0] ctrl_ff, nxt_ctrl;           // Control register
	logic [31:0] addr_ff, nxt_addr;           // Address register
	logic [EV_NUM-1:0] stat_ff, nxt_stat;     // Sticky events
	logic [EV_NUM-1:0] ien_ff, nxt_ien;       // Interrupt enables
	logic [31:0] rxDat_ff, nxt_rxDat;         // Last received word
	logic [4:0]  rxId_ff, nxt_rxId;           // Last received id
	logic [31:0] dat_ff [8];                  // Write data words
	logic [31:0] hrdata_ff, nxt_hrdata;       // Read data
	logic        addrPh;                      // Valid address phase
	logic        goPulse;                     // Start request
	logic [EV_NUM-1:0] evSet;                 // Event pulses
	logic        busy;                        // Engine active
	logic        doneEv;                      // Write complete pulse

	assign addrPh    = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign irq       = |(stat_ff & ien_ff);

	// Register next values, set wins over clear
	always_comb
	begin
		nxt_wrPend = addrPh && hwrite;
		nxt_wrAddr = addrPh ? haddr : wrAddr_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_addr   = addr_ff;
		nxt_ien    = ien_ff;
		nxt_stat   = stat_ff;
		nxt_hrdata = hrdata_ff;
		goPulse    = 1'b0;
		if (wrPend_ff)
		begin
			unique case (wrAddr_ff)
				OFS_CTRL:
				begin
					nxt_ctrl = {27'h0000000, hwdata[4:1], 1'b0};
					goPulse  = hwdata[CTL_GO] && !busy;
				end
				OFS_ADDR: nxt_addr = hwdata;
				OFS_IEN:  nxt_ien  = hwdata[EV_NUM-1:0];
				OFS_ICLR: nxt_stat = stat_ff & ~hwdata[EV_NUM-1:0];
				default:  ;  // Data words, read-only or unmapped
			endcase
		end
		nxt_stat = nxt_stat | evSet;
		if (addrPh && !hwrite)
		begin
			unique case (haddr)
				OFS_CTRL:  nxt_hrdata = ctrl_ff;
				OFS_ADDR:  nxt_hrdata = addr_ff;
				OFS_STAT:  nxt_hrdata = {28'h0000000, busy, stat_ff};
				OFS_IEN:   nxt_hrdata = {29'h00000000, ien_ff};
				OFS_RXDAT: nxt_hrdata = rxDat_ff;
				OFS_RXID:  nxt_hrdata = {27'h0000000, rxId_ff};
				default:
					nxt_hrdata = (haddr[7:5] == 3'h1) ?
						dat_ff[haddr[4:2]] : 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			ctrl_ff   <= RST_WORD;
			addr_ff   <= RST_WORD;
			ien_ff    <= '0;
			stat_ff   <= '0;
			hrdata_ff <= RST_WORD;
		end
		else
		begin
			wrPend_ff <= nxt_wrPend;
			wrAddr_ff <= nxt_wrAddr;
			ctrl_ff   <= nxt_ctrl;
			addr_ff   <= nxt_addr;
			ien_ff    <= nxt_ien;
			stat_ff   <= nxt_stat;
			hrdata_ff <= nxt_hrdata;
		end
	end

	// Data word array, one generate entry per word
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : gDat
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					dat_ff[gi] <= RST_WORD;
				else if (wrPend_ff && wrAddr_ff == OFS_DATA0 + 8'(4 * gi))
					dat_ff[gi] <= hwdata;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Receive path for external data identifiers

	// Capture incoming word and id; check bit ignored
	always_comb
	begin
		nxt_rxDat = rxDat_ff;
		nxt_rxId  = rxId_ff;
		evSet     = '0;
		if (rxWord)
		begin
			nxt_rxDat = rxAd;
			nxt_rxId  = {rxCmd[4:1], 1'b0};
			evSet[EV_RX] = 1'b1;
			evSet[EV_BERR] = rxCmd[CMD_ERR_BIT];
		end
		evSet[EV_DONE] = doneEv;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxDat_ff <= RST_WORD;
			rxId_ff  <= 5'h00;
		end
		else
		begin
			rxDat_ff <= nxt_rxDat;
			rxId_ff  <= nxt_rxId;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write request sequencer

	swi_state_e  st_ff, nxt_st;               // Sequencer state
	logic [2:0]  cnt_ff, nxt_cnt;             // Word index
	logic [2:0]  last_ff, nxt_last;           // Final word index
	swi_link_s   lnk_ff, nxt_lnk;             // Registered link outputs
	logic        blk;                         // Block write selected
	logic [1:0]  sz;                          // Size field
	logic [31:0] aAl;                         // Aligned address
	logic [2:0]  wIdx;                        // Word index with swap

	assign busy = (st_ff != ST_IDLE);
	assign blk  = ctrl_ff[CTL_BLK];
	assign sz   = ctrl_ff[CTL_SZ +: 2];
	// Big endian sends high word of each doubleword first
	assign wIdx = {cnt_ff[2:1], cnt_ff[0] ^ ctrl_ff[CTL_BIGE]};

	// Address alignment by request kind
	always_comb
	begin
		aAl = addr_ff;
		if (blk)
			aAl[2:0] = 3'h0;
		else if (sz == SZ_WORD)
			aAl[1:0] = 2'h0;
		else if (sz == SZ_HALF)
			aAl[0] = 1'b0;
	end

	// Sequencer next state and outputs
	always_comb
	begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_last = last_ff;
		nxt_lnk  = '0;
		doneEv   = 1'b0;
		unique case (st_ff)
			ST_IDLE:
				if (goPulse)
					nxt_st = ST_ADDR;
			ST_ADDR:
			begin
				nxt_lnk.valid   = 1'b1;
				nxt_lnk.ad      = aAl;
				nxt_lnk.cmd.top = 1'b0;
				nxt_lnk.cmd.typ = 1'b1;
				nxt_lnk.cmd.att = blk;
				// Reserved block codes never issued
				{nxt_lnk.cmd.err, nxt_lnk.cmd.chk} =
					blk ? {1'b0, sz[0]} : sz;
				nxt_cnt  = 3'h0;
				// Block length counts 32-bit words: 2 or 4 transfers
				nxt_last = !blk ? 3'h0 :
					(sz[0] == BLK_4W[0]) ? 3'h3 : 3'h1;
				nxt_st   = ST_DATA;
			end
			ST_DATA:
			begin
				nxt_lnk.valid   = 1'b1;
				nxt_lnk.ad      = blk ? dat_ff[wIdx] : dat_ff[0];
				nxt_lnk.cmd.top = 1'b1;
				nxt_lnk.cmd.typ = (cnt_ff != last_ff);
				nxt_lnk.cmd.att = 1'b0;
				nxt_lnk.cmd.err = 1'b0;
				nxt_lnk.cmd.chk = 1'b1;
				nxt_cnt = 3'(cnt_ff + 3'h1);
				if (cnt_ff == last_ff)
				begin
					nxt_st = ST_IDLE;
					doneEv = 1'b1;
				end
			end
			default:
				nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff   <= ST_IDLE;
			cnt_ff  <= 3'h0;
			last_ff <= 3'h0;
			lnk_ff  <= '0;
		end
		else
		begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			last_ff <= nxt_last;
			lnk_ff  <= nxt_lnk;
		end
	end

	assign adOut    = lnk_ff.ad;
	assign cmdOut   = lnk_ff.cmd;
	assign validOut = lnk_ff.valid;
	assign adOe     = lnk_ff.valid;
	assign cmdOe    = lnk_ff.valid;

endmodule : swi_write_engine

// ### bench/swi_write_engine_props.sv
// Link-side checker for the write engine.
// Assumes it is bound onto the swi_write_engine ports.
`timescale 1ns/1ps

module swi_write_engine_props
(
	input wire logic        ref_clk,  // System clock
	input wire logic        rst_n,    // Async reset, active low
	input wire logic [31:0] adOut,    // Bus out
	input wire logic        adOe,     // Bus drive enable
	input wire logic [4:0]  cmdOut,   // Command out
	input wire logic        cmdOe,    // Command drive enable
	input wire logic        validOut  // Device word valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	wire req = validOut & ~cmdOut[4];  // Address cycle

	////////////////////////////////////////////////////////////////
	AST_REQ_WR: assert property (req |-> cmdOut[3])
		else $error("request not a write");
	AST_REQ_FIRST: assert property (validOut && !$past(validOut) |-> !cmdOut[4])
		else $error("first word not a request");
	AST_ID_TOP: assert property (validOut && $past(validOut) |-> cmdOut[4])
		else $error("data id top bit low");
	AST_ID_FIXED: assert property (validOut && cmdOut[4] |-> cmdOut[2:0] == 3'h1)
		else $error("data id low bits wrong");
	AST_BLK_ALIGN: assert property (req && cmdOut[2] |-> adOut[2:0] == 3'h0 && !cmdOut[1])
		else $error("block request bad");
	AST_SGL_ALIGN: assert property (req && !cmdOut[2] && cmdOut[0] |-> !adOut[0] && !(cmdOut[1] && adOut[1]))
		else $error("single address not aligned");
	AST_BLK2_LEN: assert property (req && cmdOut[2:0] == 3'h4 |=> (validOut && cmdOut[3])[*1] ##1 (validOut && !cmdOut[3]) ##1 !validOut)
		else $error("two-word block length wrong");
	AST_BLK4_LEN: assert property (req && cmdOut[2:0] == 3'h5 |=> (validOut && cmdOut[3])[*3] ##1 (validOut && !cmdOut[3]) ##1 !validOut)
		else $error("four-word block length wrong");
	AST_SGL_LEN: assert property (req && !cmdOut[2] |=> validOut && cmdOut[4] && !cmdOut[3] ##1 !validOut)
		else $error("single write length wrong");
	AST_DRIVE: assert property (adOe == validOut && cmdOe == validOut)
		else $error("bus not driven");
endmodule : swi_write_engine_props

bind swi_write_engine swi_write_engine_props chk
	(.ref_clk, .rst_n, .adOut, .adOe, .cmdOut, .cmdOe, .validOut);

// ### bench/swi_agent_model.sv
// External agent: sends single unsolicited words.
// Assumes the bench calls send; resolves the shared wires.
`timescale 1ns/1ps

module swi_agent_model
(
	input  wire logic        ref_clk,  // System clock
	input  wire logic [31:0] adOut,    // Device bus out
	input  wire logic        adOe,     // Device drives bus
	input  wire logic [4:0]  cmdOut,   // Device command out
	input  wire logic        cmdOe,    // Device drives command
	output logic      [31:0] adIn,     // Resolved bus
	output logic      [4:0]  cmdIn,    // Resolved command
	output logic             validIn   // Agent word valid
);
	logic [31:0] agAd = 32'h0;  // Agent bus drive
	logic [4:0]  agCmd = 5'h0;  // Agent id drive
	logic [31:0] qAd = 32'h0;   // Queued word
	logic        qErr = 1'h0;   // Queued error mark
	logic        qGo = 1'h0;    // Send request
	logic        vld = 1'h0;    // Valid drive

	// Wire levels from both drivers
	assign adIn = adOe ? adOut : agAd;
	assign cmdIn = cmdOe ? cmdOut : agCmd;
	assign validIn = vld;

	// One word per cycle; released lines toggle
	always @(posedge ref_clk)
	begin
		if (qGo)
		begin
			agAd <= qAd;
			agCmd <= {3'h5, qErr, 1'h1};
			vld <= 1'h1;
		end
		else
		begin
			agAd <= ~agAd;
			agCmd <= ~agCmd;
			vld <= 1'h0;
		end
	end

	task automatic send(input logic [31:0] d, input logic e);
		@(posedge ref_clk);
		qAd <= d;
		qErr <= e;
		qGo <= 1'h1;
		@(posedge ref_clk);
		qGo <= 1'h0;
	endtask : send
endmodule : swi_agent_model

// ### bench/tb_swi_write_engine.sv
// Bench: AHB master, link monitor and agent for the write engine.
// Assumes package, design, checker and agent compiled first.
`timescale 1ns/1ps

module tb_swi_write_engine
	import swi_pkg::*;
();
	logic        ref_clk = 1'h0;  // System clock
	logic        rst_n = 1'h0;    // Reset, active low
	logic        hsel = 1'h0;     // Slave select
	logic [7:0]  haddr = 8'h0;    // Byte address
	logic [1:0]  htrans = 2'h0;   // Transfer type
	logic        hwrite = 1'h0;   // Write
	logic [2:0]  hsize = 3'h2;    // Word size
	logic [31:0] hwdata = 32'h0;  // Write data
	logic [31:0] hrdata, adOut, adIn, rdv;
	logic [4:0]  cmdOut, cmdIn;
	logic        hreadyout, hresp, adOe, cmdOe, validOut, validIn, irq;
	logic [36:0] trace[$];        // Link words seen
	int          errorCnt = 0;
	int          compares = 0;
	int          cycles = 0;

	initial forever #20 ref_clk = ~ref_clk;

	swi_write_engine uut
	(
		.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.adOut, .adOe, .adIn, .cmdOut, .cmdOe, .cmdIn, .validOut,
		.validIn, .irq
	);
	swi_agent_model agent
	(
		.ref_clk, .adOut, .adOe, .cmdOut, .cmdOe, .adIn, .cmdIn, .validIn
	);

	// Link monitor and hang limit
	always @(posedge ref_clk)
	begin
		cycles++;
		if (validOut === 1'h1)
			trace.push_back({cmdOut, adOut});
		if (cycles == 20000)
		begin
			errorCnt++;
			completeRun();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] dat(input int j);
		return 32'hc0de_0000 + 32'(j);
	endfunction : dat

	task automatic ahbXfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1) @(posedge ref_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1) @(posedge ref_clk);
		r = hrdata;
		chk(hresp, 1'h0);
	endtask : ahbXfer

	// Poll status until an event bit shows
	task automatic waitStat(input int b);
		for (int k = 0; k < 40; k++)
		begin
			ahbXfer(1'h0, OFS_STAT, 32'h0, rdv);
			if (rdv[b] === 1'h1)
				break;
		end
		chk(rdv[b], 1'h1);
	endtask : waitStat

	// One write request, then its words on the link
	task automatic xfer(input logic b, input logic [1:0] sz,
		input logic be, input logic [31:0] a);
		int          n;
		logic [31:0] ea;
		n = b ? (sz[0] ? 4 : 2) : 1;
		ea = b ? {a[31:3], 3'h0} : sz == 2'h3 ? {a[31:2], 2'h0}
			: sz == 2'h1 ? {a[31:1], 1'h0} : a;
		trace.delete();
		ahbXfer(1'h1, OFS_ADDR, a, rdv);
		ahbXfer(1'h1, OFS_CTRL, {27'h0, be, sz, b, 1'h1}, rdv);
		waitStat(EV_DONE);
		chk(trace.size(), n + 1);
		chk(trace[0], {2'h1, b, b ? {1'h0, sz[0]} : sz, ea});
		for (int i = 0; i < n; i++)
			chk(trace[i + 1], {1'h1, (i != n - 1), 3'h1, dat(i ^ be)});
		ahbXfer(1'h1, OFS_ICLR, 32'h7, rdv);
	endtask : xfer

	// Received words: status, error, interrupt and mask
	task automatic rxCheck();
		ahbXfer(1'h0, 8'h40, 32'h0, rdv);
		chk(rdv, RST_WORD);
		ahbXfer(1'h1, OFS_IEN, 32'h6, rdv);
		agent.send(32'h5a5a_0001, 1'h0);
		waitStat(EV_RX);
		chk(rdv[2:0], 3'h2);
		chk(irq, 1'h1);
		ahbXfer(1'h0, OFS_RXDAT, 32'h0, rdv);
		chk(rdv, 32'h5a5a_0001);
		ahbXfer(1'h1, OFS_ICLR, 32'h7, rdv);
		agent.send(32'h0f0f_0002, 1'h1);
		waitStat(EV_BERR);
		chk(rdv[2:0], 3'h6);
		ahbXfer(1'h0, OFS_RXID, 32'h0, rdv);
		chk(rdv[4:0], 5'h16);
		ahbXfer(1'h1, OFS_IEN, 32'h0, rdv);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'h0);
	endtask : rxCheck

	task automatic completeRun();
		if (errorCnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : completeRun

	// Main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int j = 0; j < 8; j++)
			ahbXfer(1'h1, OFS_DATA0 + 8'(4 * j), dat(j), rdv);
		for (int s = 0; s < 4; s++)
			xfer(1'h0, 2'(s), 1'h0, 32'h8000_1237);
		for (int s = 0; s < 8; s++)
			xfer(1'h1, 2'(s), 1'(s >> 2), 32'h4000_0a5d);
		rxCheck();
		completeRun();
	end
endmodule : tb_swi_write_engine
